/* File: arseq_pkg.sv */
// Constants, register map and state types of the auto-reclose sequencer
package arseq_pkg;
	localparam int NREQ     = 5;
	localparam int NSHOT    = 5;
	localparam int NKIND    = 4;
	localparam int TW       = 19;
	localparam int CLK_NS   = 10;
	localparam int TICK_MS  = 5;
	localparam int TICK_CYC = TICK_MS * 1_000_000 / CLK_NS;
	localparam int CW       = 20;

	// Settings in their own units, converted to 5 ms ticks
	localparam int TMAX_S     = 1800;
	localparam int DEAD1_MS   = 200;
	localparam int DEAD2_S    = 60;
	localparam int RECL_S     = 10;
	localparam int GREC_S     = 10;
	localparam logic [TW-1:0] TMAX_TK  = TW'(TMAX_S * 1000 / TICK_MS);
	localparam logic [TW-1:0] DEAD1_TK = TW'(DEAD1_MS / TICK_MS);
	localparam logic [TW-1:0] DEAD2_TK = TW'(DEAD2_S * 1000 / TICK_MS);
	localparam logic [TW-1:0] RECL_TK  = TW'(RECL_S * 1000 / TICK_MS);
	localparam logic [TW-1:0] GREC_TK  = TW'(GREC_S * 1000 / TICK_MS);
	localparam logic [NSHOT-1:0] SEN_RST = 5'h03;

	// Timer kinds inside one shot's group of four
	localparam logic [1:0] K_START = 2'h0;
	localparam logic [1:0] K_DEAD  = 2'h1;
	localparam logic [1:0] K_ACT   = 2'h2;
	localparam logic [1:0] K_RECL  = 2'h3;
	localparam logic [2:0] SHOT_NONE = 3'h7;

	// Register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_ISTAT = 8'h08;
	localparam logic [7:0] A_IMASK = 8'h0C;
	localparam logic [7:0] A_GREC  = 8'h10;
	localparam logic [7:0] A_SEN   = 8'h14;
	localparam logic [7:0] A_TTAB  = 8'h40;
	localparam int C_LOCKRET = 0;
	localparam int C_MRESET  = 1;

	// Interrupt sources
	localparam int NIRQ     = 4;
	localparam int I_SHOT   = 0;
	localparam int I_CLOSE  = 1;
	localparam int I_DONE   = 2;
	localparam int I_LOCK   = 3;

	typedef enum logic [2:0] {
		S_READY, S_WOPEN, S_DEAD, S_CLOSE, S_RECL, S_GREC, S_FINAL, S_LOCK
	} arseq_state_t;

	typedef struct packed {
		arseq_state_t                      st;
		logic [TW-1:0]                     tmr;
		logic [CW-1:0]                     tcnt;
		logic [2:0]                        shot;
		logic [2:0]                        reqi;
		logic [NREQ-1:0]                   req_prev;
		logic                              act;
		logic [NREQ-1:0]                   pend;
		logic [NSHOT-1:0]                  shota;
		logic                              close_req;
		logic                              alim;
		logic                              fin;
		logic                              mrst;
		logic                              lock_ret;
		logic [NIRQ-1:0]                   istat;
		logic [NIRQ-1:0]                   imask;
		logic [TW-1:0]                     grec;
		logic [NREQ-1:0][NSHOT-1:0]        sen;
		logic [NSHOT*NKIND-1:0][TW-1:0]    ttab;
		logic [31:0]                       rdata;
	} arseq_regs_t;
endpackage : arseq_pkg

/* File: arseq_top.sv */
// Auto-reclose sequencer: shots, dead/reclaim timers, lock-out, register port
`timescale 1ns/1ps
module arseq_top import arseq_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	// Register port
	input  wire logic [7:0]        i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [31:0]       o_rdata,
	// Protection stages
	input  wire logic [NREQ-1:0]   i_request,
	input  wire logic              i_critical,
	input  wire logic              i_manual_reset,
	// Breaker object
	input  wire logic              i_brk_open,
	input  wire logic              i_brk_closed,
	input  wire logic              i_obj_fail,
	output logic                   o_close_req,
	output logic                   o_final_trip,
	// Indications
	output logic                   o_reclose_active,
	output logic      [NREQ-1:0]   o_request_pending,
	output logic      [NSHOT-1:0]  o_shot_active,
	output logic                   o_global_reclaim_active,
	output logic                   o_lockout_state,
	output logic                   o_irq
);
	arseq_regs_t s_ff;
	arseq_regs_t nxt_s;

	function automatic arseq_regs_t rst_val();
		arseq_regs_t r;
		r = '0;
		r.st = S_READY;
		r.grec = GREC_TK;
		for (int i = 0; i < NREQ; i++) begin
			r.sen[i] = SEN_RST;
		end
		r.ttab[0 * NKIND + K_DEAD] = DEAD1_TK;
		r.ttab[0 * NKIND + K_RECL] = RECL_TK;
		r.ttab[1 * NKIND + K_DEAD] = DEAD2_TK;
		r.ttab[1 * NKIND + K_RECL] = RECL_TK;
		return r;
	endfunction : rst_val

	// Lowest index wins: request one has the highest priority
	function automatic logic [2:0] prio(input logic [NREQ-1:0] v);
		logic [2:0] p;
		p = SHOT_NONE;
		for (int i = NREQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				p = 3'(i);
			end
		end
		return p;
	endfunction : prio

	// First enabled shot at or after a position
	function automatic logic [2:0] shot_from(input logic [NSHOT-1:0] m, input logic [2:0] f);
		logic [2:0] p;
		p = SHOT_NONE;
		for (int i = NSHOT - 1; i >= 0; i--) begin
			if (m[i] && 3'(i) >= f) begin
				p = 3'(i);
			end
		end
		return p;
	endfunction : shot_from

	function automatic logic [TW-1:0] tval(input arseq_regs_t r, input logic [2:0] sh,
			input logic [1:0] k);
		return r.ttab[{sh, k}];
	endfunction : tval

	logic             tick;
	logic [NREQ-1:0]  rise;
	logic [2:0]       r_new;
	logic [2:0]       sh_new;
	logic [2:0]       sh_nxt;
	logic             go_start;
	logic             go_dead;
	logic             go_close;
	logic             go_recl;
	logic             go_done;
	logic             go_final;
	logic             go_lock;
	logic [NIRQ-1:0]  ev;
	logic [5:0]       tidx;

	always_comb begin
		nxt_s = s_ff;
		tick = s_ff.tcnt == CW'(TICK_CYCLES - 1);
		nxt_s.tcnt = tick ? '0 : s_ff.tcnt + 1'b1;
		if (tick && s_ff.tmr != '0) begin
			nxt_s.tmr = s_ff.tmr - 1'b1;
		end
		rise = i_request & ~s_ff.req_prev;
		nxt_s.req_prev = i_request;
		r_new = prio(rise);
		sh_new = (r_new == SHOT_NONE) ? SHOT_NONE : shot_from(s_ff.sen[r_new], '0);
		sh_nxt = shot_from(s_ff.sen[s_ff.reqi], s_ff.shot + 1'b1);
		nxt_s.fin = 1'b0;
		{go_start, go_dead, go_close, go_recl, go_done, go_final, go_lock} = '0;
		ev = '0;
		tidx = 6'((i_addr - A_TTAB) >> 2);

		// Register writes
		if (i_wr) begin
			unique case (i_addr)
				A_CTRL: begin
					nxt_s.lock_ret = i_wdata[C_LOCKRET];
					if (i_wdata[C_MRESET]) begin
						nxt_s.mrst = 1'b1;
					end
				end
				A_ISTAT: nxt_s.istat = s_ff.istat & ~i_wdata[NIRQ-1:0];
				A_IMASK: nxt_s.imask = i_wdata[NIRQ-1:0];
				A_GREC:  nxt_s.grec = (i_wdata[TW-1:0] > TMAX_TK) ? TMAX_TK : i_wdata[TW-1:0];
				default: begin
					if (i_addr >= A_SEN && i_addr < A_SEN + 8'(NREQ * 4)) begin
						nxt_s.sen[3'((i_addr - A_SEN) >> 2)] = i_wdata[NSHOT-1:0];
					end else if (i_addr >= A_TTAB && tidx < 6'(NSHOT * NKIND)) begin
						// Out-of-range settings saturate at the top of the span
						nxt_s.ttab[tidx] = (i_wdata[TW-1:0] > TMAX_TK || |i_wdata[31:TW])
							? TMAX_TK : i_wdata[TW-1:0];
					end
				end
			endcase
		end
		if (i_manual_reset) begin
			nxt_s.mrst = 1'b1;
		end

		// Register reads: data valid only in the following cycle
		nxt_s.rdata = '0;
		if (i_rd) begin
			unique case (i_addr)
				A_CTRL:  nxt_s.rdata = 32'(s_ff.lock_ret);
				A_STAT:  nxt_s.rdata = {20'h0, s_ff.mrst, s_ff.reqi, s_ff.shot, 2'h0, s_ff.st};
				A_ISTAT: nxt_s.rdata = 32'(s_ff.istat);
				A_IMASK: nxt_s.rdata = 32'(s_ff.imask);
				A_GREC:  nxt_s.rdata = 32'(s_ff.grec);
				default: begin
					if (i_addr >= A_SEN && i_addr < A_SEN + 8'(NREQ * 4)) begin
						nxt_s.rdata = 32'(s_ff.sen[3'((i_addr - A_SEN) >> 2)]);
					end else if (i_addr >= A_TTAB && tidx < 6'(NSHOT * NKIND)) begin
						nxt_s.rdata = 32'(s_ff.ttab[tidx]);
					end
				end
			endcase
		end

		unique case (s_ff.st)
			S_READY: begin
				if (sh_new != SHOT_NONE) begin
					go_start = 1'b1;
				end
			end
			S_WOPEN: begin
				if (i_brk_open && !i_request[s_ff.reqi]) begin
					go_dead = 1'b1;
				end
			end
			S_DEAD: begin
				if (s_ff.tmr == '0) begin
					go_close = 1'b1;
				end
			end
			S_CLOSE: begin
				if (i_brk_closed) begin
					nxt_s.close_req = 1'b0;
					go_recl = 1'b1;
				end else if (s_ff.alim && s_ff.tmr == '0) begin
					go_lock = 1'b1;
				end
			end
			S_RECL: begin
				// Only the request that owns the sequence steps the shot
				if (rise[s_ff.reqi]) begin
					if (sh_nxt != SHOT_NONE) begin
						nxt_s.shot = sh_nxt;
						nxt_s.shota = NSHOT'(1) << sh_nxt;
						nxt_s.st = S_WOPEN;
						ev[I_SHOT] = 1'b1;
					end else begin
						go_final = 1'b1;
					end
				end else if (s_ff.tmr == '0) begin
					go_done = 1'b1;
				end
			end
			S_GREC: begin
				if (|rise && s_ff.lock_ret) begin
					go_final = 1'b1;
				end else if (sh_new != SHOT_NONE) begin
					go_start = 1'b1;
				end else if (s_ff.tmr == '0) begin
					nxt_s.st = S_READY;
				end
			end
			S_FINAL: begin
				nxt_s.st = S_LOCK;
				ev[I_LOCK] = 1'b1;
			end
			S_LOCK: begin
				// A failure still reported keeps the sequencer locked
				if (s_ff.mrst && i_brk_closed && !i_obj_fail) begin
					nxt_s.mrst = 1'b0;
					nxt_s.st = S_READY;
				end
			end
		endcase

		if (go_start) begin
			nxt_s.act = 1'b1;
			nxt_s.reqi = r_new;
			nxt_s.pend = NREQ'(1) << r_new;
			nxt_s.shot = sh_new;
			nxt_s.shota = NSHOT'(1) << sh_new;
			nxt_s.st = S_WOPEN;
			ev[I_SHOT] = 1'b1;
		end
		if (go_dead) begin
			nxt_s.tmr = tval(s_ff, s_ff.shot, K_DEAD);
			nxt_s.tcnt = '0;
			if (nxt_s.tmr == '0) begin
				go_close = 1'b1;
			end else begin
				nxt_s.st = S_DEAD;
			end
		end
		if (go_close) begin
			nxt_s.close_req = 1'b1;
			nxt_s.tmr = tval(s_ff, s_ff.shot, K_ACT);
			nxt_s.alim = nxt_s.tmr != '0;
			nxt_s.tcnt = '0;
			nxt_s.st = S_CLOSE;
			ev[I_CLOSE] = 1'b1;
		end
		if (go_recl) begin
			nxt_s.tmr = tval(s_ff, s_ff.shot, K_RECL);
			nxt_s.tcnt = '0;
			if (nxt_s.tmr == '0) begin
				go_done = 1'b1;
			end else begin
				nxt_s.st = S_RECL;
			end
		end
		if (go_done) begin
			nxt_s.act = 1'b0;
			nxt_s.pend = '0;
			nxt_s.shota = '0;
			nxt_s.tmr = s_ff.grec;
			nxt_s.tcnt = '0;
			nxt_s.st = (s_ff.grec == '0) ? S_READY : S_GREC;
			ev[I_DONE] = 1'b1;
		end

		// Critical request (outside final trip and lock-out) and breaker failure (outside lock-out) override any sequence step
		if (i_critical && s_ff.st != S_LOCK && s_ff.st != S_FINAL) begin
			go_final = 1'b1;
		end
		if (i_obj_fail && s_ff.st != S_LOCK) begin
			go_lock = 1'b1;
		end
		if (go_final || go_lock) begin
			nxt_s.act = 1'b0;
			nxt_s.pend = '0;
			nxt_s.shota = '0;
			nxt_s.close_req = 1'b0;
			nxt_s.mrst = 1'b0;
			nxt_s.fin = go_final && !go_lock;
			nxt_s.st = go_lock ? S_LOCK : S_FINAL;
			ev = '0;
			ev[I_LOCK] = go_lock;
		end

		// A new event wins over a clear in the same cycle
		nxt_s.istat = nxt_s.istat | ev;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			s_ff <= rst_val();
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_rdata                 = s_ff.rdata;
	assign o_close_req             = s_ff.close_req;
	assign o_final_trip            = s_ff.fin;
	assign o_reclose_active        = s_ff.act;
	assign o_request_pending       = s_ff.pend;
	assign o_shot_active           = s_ff.shota;
	assign o_global_reclaim_active = s_ff.st == S_GREC;
	assign o_lockout_state         = s_ff.st == S_LOCK;
	assign o_irq                   = |(s_ff.istat & s_ff.imask);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence q_final_then_lock;
		s_ff.st == S_FINAL ##1 s_ff.st == S_LOCK && !o_reclose_active;
	endsequence

	// Neither override input is active, so the plain sequence step applies
	logic quiet;
	assign quiet = !i_critical && !i_obj_fail;

	a_start_ind: assert property (s_ff.st == S_READY && sh_new != SHOT_NONE && quiet
		|=> o_reclose_active && o_request_pending != '0 && $onehot(o_shot_active))
		else $error("indications not raised together at start");
	a_close_cause: assert property ($rose(o_close_req)
		|-> $past(s_ff.st) == S_DEAD || $past(s_ff.st) == S_WOPEN)
		else $error("close request without dead time");
	a_close_drop: assert property (s_ff.st == S_CLOSE && i_brk_closed
		|=> !o_close_req)
		else $error("close request held after breaker closed");
	a_close_hold: assert property (s_ff.st == S_CLOSE && !i_brk_closed && !s_ff.alim
		&& quiet |=> o_close_req)
		else $error("close request dropped before breaker closed");
	a_shot_step: assert property (s_ff.st == S_RECL && rise[s_ff.reqi] && quiet
		&& sh_nxt != SHOT_NONE |=> s_ff.shot > $past(s_ff.shot) && $onehot(o_shot_active))
		else $error("shot did not advance");
	a_final_lock: assert property (s_ff.st == S_RECL && rise[s_ff.reqi] && quiet
		&& sh_nxt == SHOT_NONE |=> q_final_then_lock)
		else $error("no final trip when shots ran out");
	a_lock_hold: assert property (o_lockout_state && !(s_ff.mrst && i_brk_closed)
		|=> o_lockout_state)
		else $error("lock-out left without reset");
	a_lock_ignore: assert property (o_lockout_state
		|=> !o_reclose_active && !o_close_req)
		else $error("sequence restarted from lock-out");
	a_crit_halt: assert property (i_critical && s_ff.st inside {S_DEAD, S_RECL, S_CLOSE}
		&& !i_obj_fail |=> o_final_trip ##1 o_lockout_state)
		else $error("critical request did not halt reclosing");
	a_fail_lock: assert property (i_obj_fail |=> o_lockout_state && !o_close_req)
		else $error("breaker failure did not lock out");
	a_recl_done: assert property (s_ff.st == S_RECL && s_ff.tmr == '0 && !rise[s_ff.reqi]
		&& quiet |=> !o_reclose_active && o_shot_active == '0)
		else $error("reclaim expiry did not clear indications");
	a_grec_ready: assert property (s_ff.st == S_GREC && s_ff.tmr == '0 && rise == '0
		&& quiet |=> s_ff.st == S_READY)
		else $error("global reclaim expiry did not return to ready");
	a_dead_skip: assert property (s_ff.st == S_WOPEN && go_dead && quiet
		&& tval(s_ff, s_ff.shot, K_DEAD) == '0 |=> o_close_req)
		else $error("zero dead time not skipped");
endmodule : arseq_top

/* File: arseq_brk_model.sv */
// Breaker object model: opens on trip, closes on close request or by hand
`timescale 1ns/1ps
module arseq_brk_model #(
	parameter int CLOSE_DLY = 3
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// Commands
	input  wire logic i_trip,
	input  wire logic i_man_close,
	input  wire logic i_close_req,
	// Breaker status
	output logic      o_brk_open,
	output logic      o_brk_closed
);
	int cnt_ff;

	// Starts closed, as a feeder in service
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_brk_closed <= 1'b1;
			cnt_ff       <= 0;
		end else if (i_trip) begin
			o_brk_closed <= 1'b0;
			cnt_ff       <= 0;
		end else if (i_man_close) begin
			o_brk_closed <= 1'b1;
		end else if (i_close_req && !o_brk_closed) begin
			// Close coil needs a few cycles, like a real mechanism
			cnt_ff <= cnt_ff + 1;
			if (cnt_ff == CLOSE_DLY - 1) begin
				o_brk_closed <= 1'b1;
			end
		end else begin
			cnt_ff <= 0;
		end
	end
	assign o_brk_open = !o_brk_closed;
endmodule : arseq_brk_model

/* File: tb_arseq_top.sv */
// Testbench of the auto-reclose sequencer with breaker model
`timescale 1ns/1ps
module tb_arseq_top;
	import arseq_pkg::*;
	logic            i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, i_critical = 0;
	logic            i_manual_reset = 0, i_obj_fail = 0, trp = 0, mcl = 0, ft_seen = 0;
	logic [7:0]      i_addr = 8'h00;
	logic [31:0]     i_wdata = 32'h0, d;
	logic [NREQ-1:0] i_request = '0;
	logic [31:0]     o_rdata;
	logic [NREQ-1:0] o_request_pending;
	logic [NSHOT-1:0] o_shot_active;
	logic            brk_open, brk_closed, o_close_req, o_final_trip, o_reclose_active;
	logic            o_global_reclaim_active, o_lockout_state, o_irq;
	int              mismatches = 0, compares = 0, cyc = 0, n;

	arseq_top #(.TICK_CYCLES(10)) arseq_top_inst (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_request(i_request), .i_critical(i_critical), .i_manual_reset(i_manual_reset),
		.i_brk_open(brk_open), .i_brk_closed(brk_closed), .i_obj_fail(i_obj_fail),
		.o_close_req(o_close_req), .o_final_trip(o_final_trip),
		.o_reclose_active(o_reclose_active), .o_request_pending(o_request_pending),
		.o_shot_active(o_shot_active), .o_global_reclaim_active(o_global_reclaim_active),
		.o_lockout_state(o_lockout_state), .o_irq(o_irq));
	arseq_brk_model arseq_brk_model_inst (.i_clk(i_clk), .i_resetn(i_resetn), .i_trip(trp),
		.i_man_close(mcl), .i_close_req(o_close_req), .o_brk_open(brk_open),
		.o_brk_closed(brk_closed));

	always #5 i_clk = ~i_clk;
	// Pulse is one cycle only, so latch it for the later check
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_final_trip === 1'b1) ft_seen <= 1'b1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			report_and_stop();
		end
	end

	task report_and_stop;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task tick(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask : tick

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd

	// Trip raises request two and opens the breaker; both released a cycle later
	task fault;
		@(posedge i_clk);
		i_request[1] <= 1'b1;
		trp <= 1'b1;
		@(posedge i_clk);
		i_request <= '0;
		trp <= 1'b0;
		#1;
	endtask : fault

	task wait_close(output int k);
		k = 0;
		while (o_close_req !== 1'b1 && k < 3000) begin
			tick(1);
			k = k + 1;
		end
	endtask : wait_close

	task unlock;
		@(posedge i_clk);
		i_manual_reset <= 1'b1;
		@(posedge i_clk);
		i_manual_reset <= 1'b0;
		mcl <= 1'b1;
		@(posedge i_clk);
		mcl <= 1'b0;
		tick(4);
		chk("unlock", o_lockout_state, 0);
	endtask : unlock

	initial begin
		repeat (5) @(posedge i_clk);
		i_resetn <= 1'b1;
		rd(8'h44, d);
		chk("dead1_rst", d, 40);
		rd(A_SEN + 8'h04, d);
		chk("sen_rst", d, 32'h03);
		rd(A_GREC, d);
		chk("grec_rst", d, 2000);
		rd(8'h28, d);
		chk("unmapped", d, 0);
		wr(8'h80, 32'h0007FFFF);
		rd(8'h80, d);
		chk("tmax", d, 360000);
		wr(8'h54, 30);
		wr(8'h4C, 20);
		wr(8'h5C, 20);
		wr(A_GREC, 15);
		wr(A_IMASK, 32'hF);
		$display("test registers done");

		fault();
		chk("active", o_reclose_active, 1);
		chk("pending", o_request_pending, 5'h02);
		chk("shot1", o_shot_active, 5'h01);
		wait_close(n);
		chk("dead1", n >= 400 && n <= 414, 1);
		tick(6);
		chk("close_off", o_close_req, 0);
		fault();
		chk("shot2", o_shot_active, 5'h02);
		wait_close(n);
		chk("dead2", n >= 300 && n <= 314, 1);
		tick(6);
		fault();
		tick(3);
		chk("final", ft_seen, 1);
		chk("ind_off", {o_reclose_active, o_shot_active, o_request_pending}, 0);
		chk("lock", o_lockout_state, 1);
		fault();
		tick(3);
		chk("ignored", {o_shot_active, o_close_req, o_lockout_state}, 1);
		chk("irq", o_irq, 1);
		rd(A_ISTAT, d);
		chk("istat_lock", d[I_LOCK], 1);
		wr(A_IMASK, 0);
		tick(1);
		chk("irq_mask", o_irq, 0);
		wr(A_ISTAT, 32'hF);
		wr(A_IMASK, 32'hF);
		tick(1);
		chk("irq_clr", o_irq, 0);
		unlock();
		$display("test two shots fail done");

		fault();
		wait_close(n);
		tick(186);
		chk("reclaim_run", o_reclose_active, 1);
		tick(35);
		chk("reclaim_end", {o_reclose_active, o_shot_active, o_request_pending}, 0);
		chk("grec_on", o_global_reclaim_active, 1);
		tick(165);
		chk("grec_off", o_global_reclaim_active, 0);
		rd(A_STAT, d);
		chk("ready", d[2:0], 0);
		$display("test success done");

		wr(A_CTRL, 1);
		wr(8'h44, 0);
		fault();
		wait_close(n);
		chk("dead0", n <= 5, 1);
		tick(227);
		chk("grec_on2", o_global_reclaim_active, 1);
		fault();
		tick(3);
		chk("return_lock", o_lockout_state, 1);
		unlock();
		$display("test return done");

		// Failure and critical request both arrive while reclaim is running, then a critical request arrives while ready
		fault();
		tick(4);
		@(posedge i_clk);
		i_obj_fail <= 1'b1;
		@(posedge i_clk);
		i_obj_fail <= 1'b0;
		tick(1);
		chk("fail_lock", o_lockout_state, 1);
		chk("fail_ind", {o_reclose_active, o_close_req}, 0);
		unlock();
		fault();
		tick(4);
		@(posedge i_clk);
		i_critical <= 1'b1;
		@(posedge i_clk);
		i_critical <= 1'b0;
		#1;
		chk("crit_final", o_final_trip, 1);
		tick(2);
		chk("crit_halt", {o_lockout_state, o_reclose_active, o_shot_active}, 32'h40);
		unlock();
		@(posedge i_clk);
		i_critical <= 1'b1;
		@(posedge i_clk);
		i_critical <= 1'b0;
		tick(4);
		chk("crit_lock", o_lockout_state, 1);
		unlock();
		$display("test lock-out sources done");
		report_and_stop();
	end
endmodule : tb_arseq_top
